//--- logic/rcs_cksum.sv
module rcs_cksum #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_vld,
  input wire logic [W-1:0] i_byte,
  output logic o_zero
);
  // ------------------------------------------------------------
  // Modular byte sum; a good block sums to zero
  // ------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] sum;
  } rcs_cks_type;

  rcs_cks_type s;
  rcs_cks_type next_s;

  if (W < 1) begin
    $error("rcs_cksum: W must be positive");
  end

  always_comb begin
    next_s = s;
    if (i_clear) begin
      next_s.sum = '0;
    end else if (i_vld) begin
      next_s.sum = W'(s.sum + i_byte);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_zero = (s.sum == '0);
endmodule

//--- logic/rcs_pkg.sv
package rcs_pkg;
  // ------------------------------------------------------------
  // Strap layout
  // ------------------------------------------------------------
  localparam int STRAP_W = 8;
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_SEL_W = 4;
  localparam int PROTO_BIT = 4;
  localparam int EE_EN_BIT = 5;
  // ------------------------------------------------------------
  // EEPROM search
  // ------------------------------------------------------------
  localparam logic [6:0] EE_FIRST_ADDR = 7'h50;
  localparam logic [6:0] EE_LAST_ADDR = 7'h57;
  localparam logic [1:0] RATE_1M = 2'h0;
  localparam logic [1:0] RATE_400K = 2'h1;
  localparam logic [1:0] RATE_100K = 2'h2;
  localparam logic [15:0] OFF_CFG_LO = 16'h0000;
  localparam logic [15:0] OFF_CFG_HI = 16'hF000;
  localparam logic [15:0] OFF_UPDATE = 16'h0000;
  localparam logic KIND_UPDATE = 1'h0;
  localparam logic KIND_CONFIG = 1'h1;
  // ------------------------------------------------------------
  // Actions handed to the image engine
  // ------------------------------------------------------------
  localparam logic [2:0] ACT_NONE = 3'h0;
  localparam logic [2:0] ACT_DEFAULTS = 3'h1;
  localparam logic [2:0] ACT_UPDATE = 3'h2;
  localparam logic [2:0] ACT_MERGE = 3'h3;
  localparam logic [2:0] ACT_HOTFIX = 3'h4;
  localparam logic [2:0] ACT_APPLY = 3'h5;
  // ------------------------------------------------------------
  // Status bits
  // ------------------------------------------------------------
  localparam int STATUS_W = 8;
  localparam int ST_OTP_MISSING = 0;
  localparam int ST_OTP_CKSUM = 1;
  localparam int ST_EE_ABSENT = 2;
  localparam int ST_EE_BAD = 3;
  localparam int ST_OTP_LOADED = 4;
  localparam int ST_EE_LOADED = 5;
  localparam int ST_UPDATED = 6;
  localparam int ST_HOTFIX = 7;
  localparam int TRIG_BYTES = 4;
  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [15:0] {
    S_HOLD      = 16'h0001,
    S_DEFAULTS  = 16'h0002,
    S_UPD_PROBE = 16'h0004,
    S_UPD_READ  = 16'h0008,
    S_UPD_APPLY = 16'h0010,
    S_OTP       = 16'h0020,
    S_EE_PROBE  = 16'h0040,
    S_EE_READ   = 16'h0080,
    S_EE_MERGE  = 16'h0100,
    S_HOTFIX    = 16'h0200,
    S_CAL       = 16'h0400,
    S_SER       = 16'h0800,
    S_APPLY     = 16'h1000,
    S_MON       = 16'h2000,
    S_ALARM     = 16'h4000,
    S_RUN       = 16'h8000
  } rcs_state_type;
endpackage

//--- logic/rcs_sequencer.sv
module rcs_sequencer #(
  parameter int FUNC_W = 8,
  parameter logic [FUNC_W-1:0] BOOT_FUNCS = 8'h03
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_master_reset_n,
  input wire logic [rcs_pkg::STRAP_W-1:0] i_gpio,
  output logic [rcs_pkg::STRAP_W-1:0] o_strap,
  output logic o_act_req,
  output logic [2:0] o_act_code,
  input wire logic i_act_done,
  output logic o_probe_req,
  output logic [6:0] o_dev_addr,
  output logic [1:0] o_i2c_rate,
  input wire logic i_probe_done,
  input wire logic i_probe_ack,
  output logic o_blk_req,
  output logic o_blk_kind,
  output logic [15:0] o_blk_off,
  input wire logic i_blk_byte_vld,
  input wire logic [7:0] i_blk_byte,
  input wire logic i_blk_end,
  input wire logic i_blk_fmt_ok,
  output logic o_otp_req,
  output logic [rcs_pkg::CFG_SEL_W-1:0] o_otp_sel,
  input wire logic i_otp_done,
  input wire logic i_otp_found,
  input wire logic i_otp_cksum_ok,
  input wire logic i_otp_apll_fb,
  input wire logic i_otp_spi,
  input wire logic i_hotfix_present,
  output logic o_apll_cal_start,
  input wire logic i_apll_cal_done,
  output logic o_spi_mode,
  output logic o_spi_4wire,
  output logic o_serial_en,
  input wire logic [7:0] i_clk_out_cfg,
  input wire logic [7:0] i_gpio_out_cfg,
  output logic [7:0] o_clk_out_oe_n,
  output logic [7:0] o_gpio_oe_n,
  output logic o_mon_en,
  input wire logic i_alarm_cfg,
  output logic o_alarm_en,
  output logic o_done,
  output logic [rcs_pkg::STATUS_W-1:0] o_status,
  output logic [rcs_pkg::CFG_SEL_W-1:0] o_otp_cfg_loaded,
  input wire logic i_cfg_byte_wr,
  input wire logic [1:0] i_cfg_byte_idx,
  input wire logic i_trig_wr,
  output logic o_module_trigger,
  input wire logic [FUNC_W-1:0] i_func_required,
  input wire logic [FUNC_W-1:0] i_func_idle,
  output logic [FUNC_W-1:0] o_func_pwr,
  output logic [FUNC_W-1:0] o_func_clk
);
  // ------------------------------------------------------------
  // State record
  // ------------------------------------------------------------
  typedef struct packed {
    rcs_pkg::rcs_state_type st;
    logic mr_q;
    logic [rcs_pkg::STRAP_W-1:0] strap;
    logic act_req;
    logic [2:0] act_code;
    logic probe_req;
    logic [6:0] addr;
    logic [1:0] rate;
    logic any_ack;
    logic blk_req;
    logic blk_kind;
    logic [15:0] blk_off;
    logic cks_clr;
    logic otp_req;
    logic apll_start;
    logic spi_mode;
    logic spi_4wire;
    logic serial_en;
    logic [7:0] clk_oe_n;
    logic [7:0] gpio_oe_n;
    logic mon_en;
    logic alarm_en;
    logic done;
    logic [rcs_pkg::STATUS_W-1:0] status;
    logic [rcs_pkg::CFG_SEL_W-1:0] cfg_loaded;
    logic [rcs_pkg::TRIG_BYTES-1:0] trig_mask;
    logic trig;
    logic [FUNC_W-1:0] pwr;
    logic [FUNC_W-1:0] clk_on;
  } rcs_seq_type;

  rcs_seq_type s;
  rcs_seq_type next_s;
  logic cks_zero;
  logic blk_good;

  if (FUNC_W < 1) begin
    $error("rcs_sequencer: FUNC_W must be positive");
  end

  rcs_cksum #(.W(8)) u_cksum (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(s.cks_clr),
    .i_vld(i_blk_byte_vld),
    .i_byte(i_blk_byte),
    .o_zero(cks_zero)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Value every flop takes while the master reset pin is low
  function automatic rcs_seq_type held(input rcs_seq_type c);
    rcs_seq_type r;
    r = '0;
    r.st = rcs_pkg::S_HOLD;
    r.mr_q = c.mr_q;
    r.strap = c.strap;
    r.clk_oe_n = '1;
    r.gpio_oe_n = '1;
    r.pwr = BOOT_FUNCS;
    r.clk_on = BOOT_FUNCS;
    return r;
  endfunction

  // Starts a probe of the current address in the current stage
  function automatic rcs_seq_type probe(input rcs_seq_type c);
    rcs_seq_type r;
    r = c;
    r.probe_req = 1'h1;
    r.blk_req = 1'h0;
    return r;
  endfunction

  // Moves on to the next address, then the next slower rate
  function automatic rcs_seq_type advance(input rcs_seq_type c);
    rcs_seq_type r;
    r = c;
    r.blk_req = 1'h0;
    // A failed read must go back to probing, or the stage waits for ever
    if (c.st == rcs_pkg::S_UPD_READ) r.st = rcs_pkg::S_UPD_PROBE;
    if (c.st == rcs_pkg::S_EE_READ) r.st = rcs_pkg::S_EE_PROBE;
    if (c.addr != rcs_pkg::EE_LAST_ADDR) begin
      r.addr = 7'(c.addr + 7'h01);
      r = probe(r);
    end else if (!c.any_ack && c.rate != rcs_pkg::RATE_100K) begin
      r.rate = 2'(c.rate + 2'h1);
      r.addr = rcs_pkg::EE_FIRST_ADDR;
      r = probe(r);
    end else if (c.st == rcs_pkg::S_UPD_PROBE || c.st == rcs_pkg::S_UPD_READ) begin
      r.st = rcs_pkg::S_OTP;
      r.otp_req = 1'h1;
    end else begin
      if (!c.any_ack) begin
        r.status[rcs_pkg::ST_EE_ABSENT] = 1'h1;
      end
      r.st = rcs_pkg::S_HOTFIX;
    end
    return r;
  endfunction

  // Resets the search pointer and opens a search stage
  function automatic rcs_seq_type search(input rcs_seq_type c,
                                         input rcs_pkg::rcs_state_type st);
    rcs_seq_type r;
    r = c;
    r.st = st;
    r.addr = rcs_pkg::EE_FIRST_ADDR;
    r.rate = rcs_pkg::RATE_1M;
    r.any_ack = 1'h0;
    return probe(r);
  endfunction

  // Starts a read of one block from the answering EEPROM
  function automatic rcs_seq_type read_blk(input rcs_seq_type c,
                                           input logic kind,
                                           input logic [15:0] off);
    rcs_seq_type r;
    r = c;
    r.blk_req = 1'h1;
    r.blk_kind = kind;
    r.blk_off = off;
    r.cks_clr = 1'h1;
    return r;
  endfunction

  function automatic rcs_seq_type act(input rcs_seq_type c,
                                      input logic [2:0] code);
    rcs_seq_type r;
    r = c;
    r.act_req = 1'h1;
    r.act_code = code;
    return r;
  endfunction

  // Opening of the sequence, also the target of a device update
  function automatic rcs_seq_type defaults(input rcs_seq_type c);
    rcs_seq_type r;
    r = act(c, rcs_pkg::ACT_DEFAULTS);
    r.st = rcs_pkg::S_DEFAULTS;
    r.spi_mode = c.strap[rcs_pkg::PROTO_BIT];
    r.spi_4wire = 1'h1;
    return r;
  endfunction

  // A block only counts once every byte went through the sum
  assign blk_good = i_blk_end && i_blk_fmt_ok && cks_zero;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.mr_q = i_master_reset_n;
    next_s.cks_clr = 1'h0;
    next_s.apll_start = 1'h0;
    next_s.trig = 1'h0;
    if (i_probe_done) begin
      next_s.probe_req = 1'h0;
    end
    if (i_act_done) begin
      next_s.act_req = 1'h0;
    end
    unique case (s.st)
      rcs_pkg::S_HOLD: begin
        if (i_master_reset_n && !s.mr_q) begin
          next_s.strap = i_gpio;
          next_s = defaults(next_s);
        end
      end
      rcs_pkg::S_DEFAULTS: begin
        if (i_act_done) begin
          // An applied update is not scanned for again, else it would loop
          if (s.strap[rcs_pkg::EE_EN_BIT] && !s.status[rcs_pkg::ST_UPDATED]) begin
            next_s = search(next_s, rcs_pkg::S_UPD_PROBE);
          end else begin
            next_s.st = rcs_pkg::S_OTP;
            next_s.otp_req = 1'h1;
          end
        end
      end
      rcs_pkg::S_UPD_PROBE, rcs_pkg::S_EE_PROBE: begin
        if (i_probe_done) begin
          if (i_probe_ack) begin
            next_s.any_ack = 1'h1;
            if (s.st == rcs_pkg::S_UPD_PROBE) begin
              next_s.st = rcs_pkg::S_UPD_READ;
              next_s = read_blk(next_s, rcs_pkg::KIND_UPDATE,
                                rcs_pkg::OFF_UPDATE);
            end else begin
              next_s.st = rcs_pkg::S_EE_READ;
              next_s = read_blk(next_s, rcs_pkg::KIND_CONFIG,
                                rcs_pkg::OFF_CFG_LO);
            end
          end else begin
            next_s = advance(next_s);
          end
        end
      end
      rcs_pkg::S_UPD_READ: begin
        if (i_blk_end) begin
          next_s.blk_req = 1'h0;
          if (blk_good) begin
            next_s.st = rcs_pkg::S_UPD_APPLY;
            next_s = act(next_s, rcs_pkg::ACT_UPDATE);
          end else begin
            next_s = advance(next_s);
          end
        end
      end
      rcs_pkg::S_UPD_APPLY: begin
        if (i_act_done) begin
          next_s.status[rcs_pkg::ST_UPDATED] = 1'h1;
          next_s = defaults(next_s);
        end
      end
      rcs_pkg::S_OTP: begin
        if (i_otp_done) begin
          next_s.otp_req = 1'h0;
          if (i_otp_found && i_otp_cksum_ok) begin
            next_s.status[rcs_pkg::ST_OTP_LOADED] = 1'h1;
            next_s.cfg_loaded = s.strap[rcs_pkg::CFG_SEL_LSB +: rcs_pkg::CFG_SEL_W];
            next_s.apll_start = i_otp_apll_fb;
            next_s.spi_mode = i_otp_spi;
          end else begin
            next_s.status[rcs_pkg::ST_OTP_MISSING] = !i_otp_found;
            next_s.status[rcs_pkg::ST_OTP_CKSUM] = i_otp_found;
          end
          if (s.strap[rcs_pkg::EE_EN_BIT]) begin
            next_s = search(next_s, rcs_pkg::S_EE_PROBE);
          end else begin
            next_s.st = rcs_pkg::S_HOTFIX;
          end
        end
      end
      rcs_pkg::S_EE_READ: begin
        if (i_blk_end) begin
          next_s.blk_req = 1'h0;
          if (blk_good) begin
            next_s.st = rcs_pkg::S_EE_MERGE;
            next_s = act(next_s, rcs_pkg::ACT_MERGE);
          end else begin
            next_s.status[rcs_pkg::ST_EE_BAD] = 1'h1;
            if (s.blk_off == rcs_pkg::OFF_CFG_LO) begin
              next_s = read_blk(next_s, rcs_pkg::KIND_CONFIG,
                                rcs_pkg::OFF_CFG_HI);
            end else begin
              next_s = advance(next_s);
            end
          end
        end
      end
      rcs_pkg::S_EE_MERGE: begin
        if (i_act_done) begin
          next_s.status[rcs_pkg::ST_EE_LOADED] = 1'h1;
          next_s.st = rcs_pkg::S_HOTFIX;
        end
      end
      rcs_pkg::S_HOTFIX: begin
        // Request flag doubles as "hotfix already started"
        if (s.act_req) begin
          if (i_act_done) begin
            next_s.status[rcs_pkg::ST_HOTFIX] = 1'h1;
            next_s.st = rcs_pkg::S_SER;
          end
        end else if (i_hotfix_present) begin
          next_s = act(next_s, rcs_pkg::ACT_HOTFIX);
        end else begin
          next_s.st = rcs_pkg::S_SER;
        end
        if (next_s.st == rcs_pkg::S_SER
            && (s.status[rcs_pkg::ST_OTP_LOADED] || s.status[rcs_pkg::ST_EE_LOADED])) begin
          next_s.st = rcs_pkg::S_CAL;
          next_s.apll_start = 1'h1;
        end
      end
      rcs_pkg::S_CAL: begin
        if (i_apll_cal_done) begin
          next_s.st = rcs_pkg::S_SER;
        end
      end
      rcs_pkg::S_SER: begin
        next_s.serial_en = 1'h1;
        next_s.st = rcs_pkg::S_APPLY;
        next_s = act(next_s, rcs_pkg::ACT_APPLY);
      end
      rcs_pkg::S_APPLY: begin
        if (i_act_done) begin
          next_s.clk_oe_n = ~i_clk_out_cfg;
          next_s.gpio_oe_n = ~i_gpio_out_cfg;
          next_s.st = rcs_pkg::S_MON;
        end
      end
      rcs_pkg::S_MON: begin
        next_s.mon_en = 1'h1;
        next_s.st = rcs_pkg::S_ALARM;
      end
      rcs_pkg::S_ALARM: begin
        next_s.alarm_en = i_alarm_cfg;
        next_s.done = 1'h1;
        next_s.st = rcs_pkg::S_RUN;
      end
      rcs_pkg::S_RUN: begin
        next_s.alarm_en = i_alarm_cfg;
        next_s.clk_oe_n = ~i_clk_out_cfg;
        next_s.gpio_oe_n = ~i_gpio_out_cfg;
      end
      default: begin
        next_s = held(s);
      end
    endcase

    // Module settings only take effect once the whole field is in
    if (i_trig_wr) begin
      next_s.trig = &(s.trig_mask | (i_cfg_byte_wr ? 4'h1 << i_cfg_byte_idx : 4'h0));
      next_s.trig_mask = '0;
    end else if (i_cfg_byte_wr) begin
      next_s.trig_mask[i_cfg_byte_idx] = 1'h1;
    end

    // Power state follows the required-function indicators in S_RUN only; every other state holds BOOT_FUNCS
    if (s.st == rcs_pkg::S_RUN) begin
      next_s.pwr = i_func_required;
      next_s.clk_on = i_func_required & ~i_func_idle;
    end else begin
      next_s.pwr = BOOT_FUNCS;
      next_s.clk_on = BOOT_FUNCS;
    end

    if (!i_master_reset_n) begin
      next_s = held(next_s);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= held('0);
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_strap = s.strap;
  assign o_act_req = s.act_req;
  assign o_act_code = s.act_code;
  assign o_probe_req = s.probe_req;
  assign o_dev_addr = s.addr;
  assign o_i2c_rate = s.rate;
  assign o_blk_req = s.blk_req;
  assign o_blk_kind = s.blk_kind;
  assign o_blk_off = s.blk_off;
  assign o_otp_req = s.otp_req;
  assign o_otp_sel = s.strap[rcs_pkg::CFG_SEL_LSB +: rcs_pkg::CFG_SEL_W];
  assign o_apll_cal_start = s.apll_start;
  assign o_spi_mode = s.spi_mode;
  assign o_spi_4wire = s.spi_4wire;
  assign o_serial_en = s.serial_en;
  assign o_clk_out_oe_n = s.clk_oe_n;
  assign o_gpio_oe_n = s.gpio_oe_n;
  assign o_mon_en = s.mon_en;
  assign o_alarm_en = s.alarm_en;
  assign o_done = s.done;
  assign o_status = s.status;
  assign o_otp_cfg_loaded = s.cfg_loaded;
  assign o_module_trigger = s.trig;
  assign o_func_pwr = s.pwr;
  assign o_func_clk = s.clk_on;
endmodule

//--- test/rcs_eeprom_model.sv
module rcs_eeprom_model (
  input wire logic i_clk,
  input wire logic [6:0] i_ee_addr,
  input wire logic [1:0] i_ee_rate,
  input wire logic i_probe_req,
  input wire logic [6:0] i_dev_addr,
  input wire logic [1:0] i_i2c_rate,
  input wire logic i_blk_req,
  input wire logic i_blk_kind,
  input wire logic [15:0] i_blk_off,
  input wire logic i_upd_ok,
  output logic o_probe_done = 1'b0,
  output logic o_probe_ack = 1'b0,
  output logic o_byte_vld = 1'b0,
  output logic [7:0] o_byte = 8'h00,
  output logic o_blk_end = 1'b0,
  output logic o_fmt_ok = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  logic [7:0] img [4] = '{8'h12, 8'h34, 8'h56, 8'h64};
  // Answers alternate fast and slow so no fixed latency is assumed
  always begin : probe_answer
    @(posedge i_clk);
    if (i_probe_req) begin
      slow <= ~slow;
      repeat (slow ? 3 : 1) @(posedge i_clk);
      o_probe_ack <= i_dev_addr == i_ee_addr && i_i2c_rate == i_ee_rate;
      o_probe_done <= 1'b1;
      @(posedge i_clk);
      o_probe_done <= 1'b0;
      o_probe_ack <= ~o_probe_ack;
    end
  end
  always begin : block_answer
    @(posedge i_clk);
    if (i_blk_req) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge i_clk);
        o_byte_vld <= 1'b1;
        o_byte <= (k == 3 && i_blk_off == 16'h0000 && i_blk_kind) ? 8'h65 : img[k];
      end
      @(posedge i_clk);
      o_byte_vld <= 1'b0;
      o_byte <= ~o_byte;
      @(posedge i_clk);
      o_blk_end <= 1'b1;
      // Update headers parse only when the bench stores an update
      o_fmt_ok <= i_blk_kind | i_upd_ok;
      @(posedge i_clk);
      o_blk_end <= 1'b0;
      o_fmt_ok <= ~o_fmt_ok;
    end
  end
endmodule

//--- test/rcs_seq_monitor.sv
module rcs_seq_monitor #(
  parameter int FUNC_W = 8,
  parameter logic [FUNC_W-1:0] BOOT_FUNCS = 8'h03
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_master_reset_n,
  input wire logic [rcs_pkg::STRAP_W-1:0] i_gpio,
  input wire logic [rcs_pkg::STRAP_W-1:0] o_strap,
  input wire logic o_act_req,
  input wire logic [2:0] o_act_code,
  input wire logic o_probe_req,
  input wire logic [6:0] o_dev_addr,
  input wire logic o_blk_req,
  input wire logic [15:0] o_blk_off,
  input wire logic i_trig_wr,
  input wire logic o_module_trigger,
  input wire logic o_spi_mode,
  input wire logic o_spi_4wire,
  input wire logic o_serial_en,
  input wire logic [7:0] o_gpio_oe_n,
  input wire logic [7:0] o_clk_out_oe_n,
  input wire logic o_mon_en,
  input wire logic i_alarm_cfg,
  input wire logic o_alarm_en,
  input wire logic o_done,
  input wire logic [rcs_pkg::STATUS_W-1:0] o_status,
  input wire logic [FUNC_W-1:0] i_func_required,
  input wire logic [FUNC_W-1:0] i_func_idle,
  input wire logic [FUNC_W-1:0] o_func_pwr,
  input wire logic [FUNC_W-1:0] o_func_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  // Release edges seen straight out of i_rst are not real pin edges
  sequence start_s;
    !$past(i_rst) && $rose(i_master_reset_n);
  endsequence
  sequence defaults_s;
    o_act_req && o_act_code == 3'h1 && o_spi_4wire && o_spi_mode == o_strap[4];
  endsequence
  sequence tail_s;
    !o_alarm_en ##1 o_alarm_en == i_alarm_cfg && o_done;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  strap_latch_a: assert property (start_s |=> o_strap == $past(i_gpio))
    else $error("straps not latched at release");
  defaults_first_a: assert property (start_s |=> defaults_s)
    else $error("defaults stage not first");
  hold_pins_a: assert property (!i_master_reset_n |=> &o_clk_out_oe_n && &o_gpio_oe_n)
    else $error("pins driven in master reset");
  pins_after_serial_a: assert property (!o_serial_en |-> &o_clk_out_oe_n)
    else $error("outputs enabled before serial");
  monitor_then_alarm_a: assert property ($rose(o_mon_en) |-> tail_s)
    else $error("alarm step out of order");
  probe_range_a: assert property (o_probe_req |-> o_dev_addr inside {[7'h50:7'h57]})
    else $error("probe address out of range");
  block_offset_a: assert property (o_blk_req |-> o_blk_off inside {16'h0000, 16'hF000})
    else $error("block offset not allowed");
  trigger_cause_a: assert property (o_module_trigger |-> $past(i_trig_wr))
    else $error("trigger without write");
  status_sticky_a: assert property (i_master_reset_n |=> (o_status & $past(o_status)) == $past(o_status))
    else $error("status bit lost");
  power_boot_a: assert property (!o_done && !$past(o_done) |-> o_func_pwr == BOOT_FUNCS)
    else $error("boot power set wrong");
  power_run_a: assert property (o_done && $past(o_done) |->
      o_func_clk == ($past(i_func_required) & ~$past(i_func_idle)))
    else $error("run clock gating wrong");
endmodule

bind rcs_sequencer rcs_seq_monitor #(.FUNC_W(FUNC_W), .BOOT_FUNCS(BOOT_FUNCS)) rcs_seq_monitor_inst (.*);

//--- test/reset_config_sequencer_test.sv
module reset_config_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, i_master_reset_n, o_act_req, i_act_done, o_probe_req, i_probe_done;
  logic i_probe_ack, o_blk_req, o_blk_kind, i_blk_byte_vld, i_blk_end, i_blk_fmt_ok;
  logic o_otp_req, i_otp_done, i_otp_found, i_otp_cksum_ok, i_otp_apll_fb, i_otp_spi;
  logic i_hotfix_present, o_apll_cal_start, i_apll_cal_done, o_spi_mode, o_spi_4wire;
  logic o_serial_en, o_mon_en, i_alarm_cfg, o_alarm_en, o_done, i_cfg_byte_wr, i_trig_wr;
  logic o_module_trigger, done_q, upd_ok;
  logic [1:0] o_i2c_rate, i_cfg_byte_idx;
  logic [2:0] o_act_code;
  logic [3:0] o_otp_sel, o_otp_cfg_loaded;
  logic [6:0] o_dev_addr, ee_addr;
  logic [15:0] o_blk_off;
  logic [7:0] i_gpio, o_strap, i_blk_byte, i_clk_out_cfg, i_gpio_out_cfg, o_clk_out_oe_n;
  logic [7:0] o_gpio_oe_n, o_status, i_func_required, i_func_idle, o_func_pwr, o_func_clk;
  logic [7:0] lfsr = 8'h53;
  logic [7:0] exp_status [$];
  logic [7:0] exp_strap [$];
  logic [2:0] exp_act [$];
  int err_count = 0, checked = 0, cal_cnt = 0, cycles = 0;
  rcs_sequencer rcs_sequencer_inst (.*);
  rcs_eeprom_model rcs_eeprom_model_inst (.i_clk(i_clk), .i_ee_addr(ee_addr),
    .i_ee_rate(rcs_pkg::RATE_400K), .i_probe_req(o_probe_req), .i_dev_addr(o_dev_addr),
    .i_i2c_rate(o_i2c_rate), .i_blk_req(o_blk_req), .i_blk_kind(o_blk_kind), .i_upd_ok(upd_ok),
    .i_blk_off(o_blk_off), .o_probe_done(i_probe_done), .o_probe_ack(i_probe_ack),
    .o_byte_vld(i_blk_byte_vld), .o_byte(i_blk_byte), .o_blk_end(i_blk_end),
    .o_fmt_ok(i_blk_fmt_ok));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s: expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Far-side engines; the action engine also checks stage order
  // ------------------------------------------------------------
  always begin : act_engine
    @(posedge i_clk);
    if (o_act_req === 1'b1) begin
      chk("action code", exp_act.pop_front(), o_act_code);
      repeat (2) @(posedge i_clk);
      i_act_done <= 1'b1;
      @(posedge i_clk);
      i_act_done <= 1'b0;
    end
  end
  always begin : otp_engine
    @(posedge i_clk);
    if (o_otp_req === 1'b1) begin
      chk("otp select", exp_strap[0][3:0], o_otp_sel);
      @(posedge i_clk);
      i_otp_done <= 1'b1;
      @(posedge i_clk);
      i_otp_done <= 1'b0;
    end
  end
  // Short answer, but a calibration request in the cycle right after another one is missed
  always begin : cal_engine
    @(posedge i_clk);
    if (o_apll_cal_start === 1'b1) begin
      cal_cnt++;
      i_apll_cal_done <= 1'b1;
      @(posedge i_clk);
      i_apll_cal_done <= 1'b0;
    end
  end
  always @(posedge i_clk) begin : done_watch
    done_q <= o_done;
    cycles++;
    if (o_done === 1'b1 && done_q !== 1'b1) begin
      chk("status", exp_status.pop_front(), o_status);
      chk("strap", exp_strap.pop_front(), o_strap);
    end
    if (cycles == 20000) begin
      err_count++;
      print_verdict;
    end
  end
  // ------------------------------------------------------------
  // One full reset sequence; otp = found, checksum ok, divider, spi
  // ------------------------------------------------------------
  task automatic run_seq(input string name, input logic [7:0] gpio, input logic [3:0] otp,
      input logic [6:0] addr, input logic [7:0] status, input logic [2:0] acts [$],
      input int cals);
    int c0;
    @(posedge i_clk);
    i_master_reset_n <= 1'b0;
    i_gpio <= gpio;
    {i_otp_found, i_otp_cksum_ok, i_otp_apll_fb, i_otp_spi} <= otp;
    i_hotfix_present <= status[7];
    ee_addr <= addr;
    exp_status.push_back(status);
    exp_strap.push_back(gpio);
    exp_act = acts;
    repeat (3) @(posedge i_clk);
    c0 = cal_cnt;
    i_master_reset_n <= 1'b1;
    @(posedge i_clk);
    lfsr = lfsr_next(lfsr);
    // Straps move after the latch and must not leak into the sequence
    i_gpio <= ~gpio;
    i_func_required <= lfsr;
    i_func_idle <= lfsr_next(lfsr);
    while (o_done !== 1'b1) @(posedge i_clk);
    @(posedge i_clk);
    chk("cal pulses", cals, cal_cnt - c0);
    chk("oe_n", {~i_gpio_out_cfg, ~i_clk_out_cfg}, {o_gpio_oe_n, o_clk_out_oe_n});
    chk("power", {i_func_required & ~i_func_idle, i_func_required},
      {o_func_clk, o_func_pwr});
    chk("cfg loaded", otp[3] & otp[2] ? gpio[3:0] : 4'h0, o_otp_cfg_loaded);
    chk("tail flags", {otp[3] & otp[2] ? otp[0] : gpio[4], 3'h7},
      {o_spi_mode, o_serial_en, o_mon_en, o_alarm_en});
    $display("test %s done", name);
  endtask
  task automatic trig(input int n, input logic exp);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      i_cfg_byte_wr <= 1'b1;
      i_cfg_byte_idx <= 2'(k);
    end
    @(posedge i_clk);
    i_cfg_byte_wr <= 1'b0;
    i_trig_wr <= 1'b1;
    @(posedge i_clk);
    i_trig_wr <= 1'b0;
    #1;
    chk("trigger", exp, o_module_trigger);
  endtask
  initial begin
    {i_rst, i_master_reset_n, i_act_done, i_otp_done, i_apll_cal_done} = 5'h10;
    {i_otp_found, i_otp_cksum_ok, i_otp_apll_fb, i_otp_spi, i_hotfix_present} = 5'h00;
    {i_cfg_byte_wr, i_cfg_byte_idx, i_trig_wr, i_alarm_cfg} = 5'h01;
    {i_gpio, i_func_required, i_func_idle, ee_addr, upd_ok} = 32'h0;
    i_clk_out_cfg = 8'h5A;
    i_gpio_out_cfg = 8'hC3;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    run_seq("otp", {4'h0, lfsr[3:0]}, 4'hF, 7'h00, 8'h90, '{3'h1, 3'h4, 3'h5}, 2);
    trig(4, 1'b1);
    trig(3, 1'b0);
    run_seq("eeprom", {4'h2, lfsr[3:0]}, 4'h0, 7'h53, 8'h29, '{3'h1, 3'h3, 3'h5}, 1);
    run_seq("none", {4'h3, lfsr[3:0]}, 4'hA, 7'h00, 8'h06, '{3'h1, 3'h5}, 0);
    upd_ok <= 1'b1;
    run_seq("update", {4'h2, lfsr[3:0]}, 4'h0, 7'h51, 8'h69,
      '{3'h1, 3'h2, 3'h1, 3'h3, 3'h5}, 1);
    print_verdict;
  end
endmodule
